// [core/mcp_pkg.sv]
// shared constants, register map and enumerations of the pwm bank
`default_nettype none
package mcp_pkg;
  localparam int NUM_CH = 9;
  localparam int NUM_PIN = 16;
  localparam int DIV_STEPS = 32;
  // system clock rate in hertz (25 MHz)
  localparam logic [31:0] CLK_HZ = 32'h017D7840;
  localparam logic [31:0] PCT_DIV = 32'h00000064;
  localparam logic [6:0] DUTY_MAX = 7'h64;
  // register byte addresses
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_FREQ = 8'h04;
  localparam logic [7:0] OFS_DUTY = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_PERIOD_BASE = 8'h40;
  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_CH_LSB = 4;
  localparam int CMD_PIN_LSB = 8;
  // status word fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_RUN_LSB = 16;
  // reset values
  localparam logic [31:0] FREQ_RST = 32'h00000000;
  localparam logic [6:0] DUTY_RST = 7'h00;
  typedef enum logic [1:0] {OP_CONFIGURE, OP_ACTIVATE, OP_DUTY, OP_STOP} mcp_op_e;
  typedef enum logic [1:0] {ST_IDLE, ST_DIV_PER, ST_DIV_HIGH} mcp_fsm_e;
endpackage
`default_nettype wire

// [core/mcp_ifs.sv]
// interfaces between the pwm controller, its channel generators and the divider
`timescale 1ns/10ps
`default_nettype none
interface mcp_chan_if;
  logic [31:0] period;
  logic [31:0] high;
  logic run;
  logic wave;
  modport ctrl (output period, output high, output run, input wave);
  modport gen (input period, input high, input run, output wave);
endinterface

interface mcp_div_if;
  logic start;
  logic [31:0] num;
  logic [31:0] den;
  logic [31:0] quot;
  logic done;
  modport ctrl (output start, output num, output den, input quot, input done);
  modport div (input start, input num, input den, output quot, output done);
endinterface
`default_nettype wire

// [core/mcp_divider.sv]
// serial restoring divider, one quotient bit per clock
`timescale 1ns/10ps
`default_nettype none
module mcp_divider (
  input wire logic clk_sys,
  input wire logic sys_rst,
  mcp_div_if.div dv
);
  typedef struct packed {
    logic [32:0] rem;
    logic [31:0] quot;
    logic [31:0] den;
    logic [5:0] cnt;
    logic busy;
    logic done;
  } mcp_div_s;

  mcp_div_s st;
  mcp_div_s next_st;
  logic [32:0] trial;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    trial = {st.rem[31:0], st.quot[31]};
    if (dv.start && !st.busy) begin
      next_st.rem = '0;
      next_st.quot = dv.num;
      next_st.den = dv.den;
      next_st.cnt = 6'(mcp_pkg::DIV_STEPS);
      next_st.busy = 1'b1;
    end else if (st.busy) begin
      if (trial >= {1'b0, st.den}) begin
        next_st.rem = trial - {1'b0, st.den};
        next_st.quot = {st.quot[30:0], 1'b1};
      end else begin
        next_st.rem = trial;
        next_st.quot = {st.quot[30:0], 1'b0};
      end
      next_st.cnt = st.cnt - 6'h01;
      if (st.cnt == 6'h01) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dv.quot = st.quot;
  assign dv.done = st.done;
endmodule
`default_nettype wire

// [core/mcp_chan_gen.sv]
// one pwm channel: period counter with boundary-loaded compare values
`timescale 1ns/10ps
`default_nettype none
module mcp_chan_gen (
  input wire logic clk_sys,
  input wire logic sys_rst,
  mcp_chan_if.gen ch
);
  typedef struct packed {
    logic [31:0] cnt;
    logic [31:0] act_period;
    logic [31:0] act_high;
    logic wave;
  } mcp_gen_s;

  mcp_gen_s st;
  mcp_gen_s next_st;
  logic at_wrap;

  assign at_wrap = ch.run && (st.cnt + 32'h00000001 >= st.act_period);

  always_comb begin
    next_st = st;
    if (!ch.run) begin
      // idle: output low, compare values follow software freely
      next_st.cnt = '0;
      next_st.act_period = ch.period;
      next_st.act_high = ch.high;
      next_st.wave = 1'b0;
    end else begin
      // high while count is below the high time; high >= period gives
      // a constant high, zero gives a constant low
      next_st.wave = st.cnt < st.act_high;
      if (at_wrap) begin
        // new values only at the period boundary, so no runt pulse
        next_st.cnt = '0;
        next_st.act_period = ch.period;
        next_st.act_high = ch.high;
      end else begin
        next_st.cnt = st.cnt + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ch.wave = st.wave;

  chk_full_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ch.run && st.act_high != 32'h00000000 && st.act_high >= st.act_period) |=> st.wave)
    else $error("full duty produced a low cycle");
  chk_zero_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ch.run && st.act_high == 32'h00000000) |=> !st.wave)
    else $error("zero duty produced a high cycle");
  chk_period_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (at_wrap && $past(ch.run)) |=> (st.cnt == 32'h00000000))
    else $error("period counter did not wrap at period end");
  chk_boundary_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ch.run && $past(ch.run) && $changed(st.act_high)) |-> $past(at_wrap))
    else $error("duty value changed in mid period");
endmodule
`default_nettype wire

// [core/mcp_pwm_top.sv]
// nine-channel pwm bank with pin routing and command register port
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - nine independent channels, each routed to a selectable output pin.
// - duty of one hundred percent keeps the output high all the time.
// - duty of zero percent keeps the output low all the time.
// - fifty percent duty gives equal high and low halves when the period is an even number of clocks.
// - period repeats at the programmed frequency, period being one over hertz.
// - duty setting takes zero to one hundred, percent of period spent high.
// - activating connects the channel waveform to its chosen pin.
// - duty may change while the channel runs, no stop or reconfigure needed.
// - a stop command ends waveform generation on that channel.
// - channels are numbered one to nine in every command.
module mcp_pwm_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [mcp_pkg::NUM_PIN-1:0] pin_out
);
  typedef struct packed {
    mcp_pkg::mcp_fsm_e fsm;
    logic [31:0] freq;
    logic [6:0] duty_in;
    logic [mcp_pkg::NUM_CH-1:0][6:0] duty;
    logic [mcp_pkg::NUM_CH-1:0][31:0] period;
    logic [mcp_pkg::NUM_CH-1:0][31:0] high;
    logic [mcp_pkg::NUM_CH-1:0][3:0] map;
    logic [mcp_pkg::NUM_CH-1:0] run;
    logic [3:0] tgt;
    logic err;
    logic div_start;
    logic [31:0] div_num;
    logic [31:0] div_den;
    logic [31:0] rdata;
    logic [mcp_pkg::NUM_PIN-1:0] pin_out;
  } mcp_top_s;

  mcp_top_s st;
  mcp_top_s next_st;

  logic cmd_wr;
  mcp_pkg::mcp_op_e cmd_op;
  logic [3:0] cmd_ch;
  logic [3:0] cmd_pin;
  logic [3:0] cidx;
  logic ch_ok;
  logic idle;
  logic [6:0] duty_clamped;
  logic [31:0] per_q;
  logic [31:0] status_word;
  logic [mcp_pkg::NUM_CH-1:0] wave;

  mcp_div_if div_bus ();
  mcp_chan_if ch_if [mcp_pkg::NUM_CH] ();

  assign cmd_wr = reg_wr && (reg_addr == mcp_pkg::OFS_CMD);
  assign cmd_op = mcp_pkg::mcp_op_e'(reg_wdata[mcp_pkg::CMD_OP_LSB +: 2]);
  assign cmd_ch = reg_wdata[mcp_pkg::CMD_CH_LSB +: 4];
  assign cmd_pin = reg_wdata[mcp_pkg::CMD_PIN_LSB +: 4];
  assign cidx = cmd_ch - 4'h1;
  assign idle = (st.fsm == mcp_pkg::ST_IDLE);
  // channels are named one to nine; zero and ten upward are refused
  assign ch_ok = (cmd_ch != 4'h0) && (cmd_ch <= 4'(mcp_pkg::NUM_CH));
  // out-of-range duty is clamped rather than refused
  assign duty_clamped = (reg_wdata > {25'h0, mcp_pkg::DUTY_MAX}) ? mcp_pkg::DUTY_MAX
                        : reg_wdata[6:0];
  // a frequency above the clock rate still gives a one-cycle period
  assign per_q = (div_bus.quot == 32'h00000000) ? 32'h00000001 : div_bus.quot;
  assign status_word = {7'h00, st.run, 14'h0000, st.err, !idle};

  assign div_bus.start = st.div_start;
  assign div_bus.num = st.div_num;
  assign div_bus.den = st.div_den;

  mcp_divider i_mcp_divider (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .dv(div_bus)
  );

  for (genvar i = 0; i < mcp_pkg::NUM_CH; i++) begin : g_ch
    assign ch_if[i].period = st.period[i];
    assign ch_if[i].high = st.high[i];
    assign ch_if[i].run = st.run[i];
    assign wave[i] = ch_if[i].wave;
    mcp_chan_gen i_mcp_chan_gen (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .ch(ch_if[i])
    );

    // per-channel checks: routing, stop and period read-back
    chk_route_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st.run[i] && wave[i]) |=> st.pin_out[$past(st.map[i])])
      else $error("running channel did not reach its pin");
    chk_wave_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!st.run[i]) |=> !wave[i])
      else $error("stopped channel kept its waveform");
    chk_period_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (reg_rd && reg_addr == mcp_pkg::OFS_PERIOD_BASE + 8'(4 * i))
      |=> (reg_rdata == $past(st.period[i])))
      else $error("period read back wrong");
  end

  always_comb begin
    next_st = st;
    next_st.div_start = 1'b0;

    if (reg_wr && reg_addr == mcp_pkg::OFS_FREQ) begin
      next_st.freq = reg_wdata;
    end
    if (reg_wr && reg_addr == mcp_pkg::OFS_DUTY) begin
      next_st.duty_in = duty_clamped;
    end

    case (st.fsm)
      mcp_pkg::ST_IDLE: begin
        if (cmd_wr) begin
          next_st.err = 1'b0;
          if (!ch_ok) begin
            next_st.err = 1'b1;
          end else begin
            case (cmd_op)
              mcp_pkg::OP_CONFIGURE: begin
                if (st.freq == 32'h00000000) begin
                  // zero hertz has no period
                  next_st.err = 1'b1;
                end else begin
                  // period in clocks is clock rate over hertz
                  next_st.tgt = cidx;
                  next_st.duty[cidx] = st.duty_in;
                  next_st.div_num = mcp_pkg::CLK_HZ;
                  next_st.div_den = st.freq;
                  next_st.div_start = 1'b1;
                  next_st.fsm = mcp_pkg::ST_DIV_PER;
                end
              end
              mcp_pkg::OP_ACTIVATE: begin
                next_st.map[cidx] = cmd_pin;
                next_st.run[cidx] = 1'b1;
              end
              mcp_pkg::OP_DUTY: begin
                // channel keeps running; generator picks the value up at wrap
                next_st.tgt = cidx;
                next_st.duty[cidx] = st.duty_in;
                next_st.div_num = 32'(st.period[cidx] * 32'(st.duty_in));
                next_st.div_den = mcp_pkg::PCT_DIV;
                next_st.div_start = 1'b1;
                next_st.fsm = mcp_pkg::ST_DIV_HIGH;
              end
              mcp_pkg::OP_STOP: begin
                next_st.run[cidx] = 1'b0;
              end
              default: begin
                next_st.err = 1'b1;
              end
            endcase
          end
        end
      end
      mcp_pkg::ST_DIV_PER: begin
        if (cmd_wr) begin
          next_st.err = 1'b1;
        end
        if (div_bus.done) begin
          next_st.period[st.tgt] = per_q;
          next_st.div_num = 32'(per_q * 32'(st.duty[st.tgt]));
          next_st.div_den = mcp_pkg::PCT_DIV;
          next_st.div_start = 1'b1;
          next_st.fsm = mcp_pkg::ST_DIV_HIGH;
        end
      end
      mcp_pkg::ST_DIV_HIGH: begin
        if (cmd_wr) begin
          next_st.err = 1'b1;
        end
        if (div_bus.done) begin
          // high time in clocks; 100 gives the whole period, 0 gives none
          next_st.high[st.tgt] = div_bus.quot;
          next_st.fsm = mcp_pkg::ST_IDLE;
        end
      end
      default: begin
        next_st.fsm = mcp_pkg::ST_IDLE;
      end
    endcase

    // routing: a pin carries the OR of running channels mapped to it,
    // so a stopped channel drops off its pin and no longer drives it high
    next_st.pin_out = '0;
    for (int p = 0; p < mcp_pkg::NUM_PIN; p++) begin
      for (int c = 0; c < mcp_pkg::NUM_CH; c++) begin
        if (st.run[c] && st.map[c] == 4'(p) && wave[c]) begin
          next_st.pin_out[p] = 1'b1;
        end
      end
    end

    // read data stand only in the cycle after the read strobe
    next_st.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        mcp_pkg::OFS_FREQ: next_st.rdata = st.freq;
        mcp_pkg::OFS_DUTY: next_st.rdata = {25'h0, st.duty_in};
        mcp_pkg::OFS_STATUS: next_st.rdata = status_word;
        default: begin
          for (int c = 0; c < mcp_pkg::NUM_CH; c++) begin
            if (reg_addr == mcp_pkg::OFS_PERIOD_BASE + 8'(4 * c)) begin
              next_st.rdata = st.period[c];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign pin_out = st.pin_out;

  chk_duty_clamp: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && reg_addr == mcp_pkg::OFS_DUTY && reg_wdata > {25'h0, mcp_pkg::DUTY_MAX})
    |=> (st.duty_in == mcp_pkg::DUTY_MAX))
    else $error("duty above one hundred not clamped");
  chk_bad_index: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_wr && idle && !ch_ok) |=> (st.err && st.run == $past(st.run) && idle))
    else $error("command with bad channel index was acted on");
  chk_activate_run: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_wr && idle && ch_ok && cmd_op == mcp_pkg::OP_ACTIVATE)
    |=> (st.run[$past(cidx)] && st.map[$past(cidx)] == $past(cmd_pin)))
    else $error("activate did not start and route the channel");
  chk_stop_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_wr && idle && ch_ok && cmd_op == mcp_pkg::OP_STOP) |=> !st.run[$past(cidx)])
    else $error("stop did not halt the channel");
  chk_stop_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st.run == '0) |=> (st.pin_out == '0))
    else $error("pin high with no channel running");
  chk_duty_live: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_wr && idle && ch_ok && cmd_op == mcp_pkg::OP_DUTY)
    |=> (!idle && st.run == $past(st.run)) ##[1:40] idle)
    else $error("duty update stalled or disturbed running channels");
  chk_config_done: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_wr && idle && ch_ok && cmd_op == mcp_pkg::OP_CONFIGURE
     && st.freq != 32'h00000000) |=> ##[1:90] idle)
    else $error("configure did not finish");

  // register port and command acceptance
  chk_busy_refuse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_wr && !idle)
    |=> (st.err && st.run == $past(st.run) && st.map == $past(st.map)))
    else $error("command acted on while a division ran");
  chk_freq_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && reg_addr == mcp_pkg::OFS_FREQ)
    |=> (st.freq == $past(reg_wdata)))
    else $error("frequency write lost");
  chk_duty_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && reg_addr == mcp_pkg::OFS_DUTY && reg_wdata <= {25'h0, mcp_pkg::DUTY_MAX})
    |=> (st.duty_in == $past(reg_wdata[6:0])))
    else $error("duty write lost");
  chk_freq_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && reg_addr == mcp_pkg::OFS_FREQ)
    |=> (st.rdata == $past(st.freq)))
    else $error("frequency read back wrong");
  chk_status_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && reg_addr == mcp_pkg::OFS_STATUS)
    |=> (st.rdata == $past(status_word)))
    else $error("status read back wrong");
  chk_zero_freq: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_wr && idle && ch_ok && cmd_op == mcp_pkg::OP_CONFIGURE && st.freq == 32'h00000000)
    |=> (st.err && idle))
    else $error("configure at zero hertz was acted on");
  chk_config_copy: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_wr && idle && ch_ok && cmd_op == mcp_pkg::OP_CONFIGURE && st.freq != 32'h00000000)
    |=> (st.duty[$past(cidx)] == $past(st.duty_in) && st.div_den == $past(st.freq)))
    else $error("configure did not take frequency and duty");
  chk_duty_copy: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_wr && idle && ch_ok && cmd_op == mcp_pkg::OP_DUTY)
    |=> (st.duty[$past(cidx)] == $past(st.duty_in)))
    else $error("duty update did not take the new duty");
  chk_err_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_wr && idle && ch_ok && (cmd_op == mcp_pkg::OP_ACTIVATE || cmd_op == mcp_pkg::OP_STOP))
    |=> !st.err)
    else $error("accepted command left the error flag set");
  chk_activate_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_wr && idle && ch_ok && cmd_op == mcp_pkg::OP_ACTIVATE)
    |=> ((st.run & ~(9'h001 << $past(cidx))) == ($past(st.run) & ~(9'h001 << $past(cidx)))))
    else $error("activate disturbed another channel");
  chk_stop_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_wr && idle && ch_ok && cmd_op == mcp_pkg::OP_STOP)
    |=> ((st.run & ~(9'h001 << $past(cidx))) == ($past(st.run) & ~(9'h001 << $past(cidx)))))
    else $error("stop disturbed another channel");

  // state that only a command or a finished division may change
  chk_run_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!cmd_wr) |=> (st.run == $past(st.run)))
    else $error("run mask changed with no command");
  chk_map_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!cmd_wr) |=> (st.map == $past(st.map)))
    else $error("pin map changed with no command");
  chk_err_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!cmd_wr) |=> (st.err == $past(st.err)))
    else $error("error flag changed with no command");
  chk_period_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st.fsm != mcp_pkg::ST_DIV_PER) |=> (st.period == $past(st.period)))
    else $error("period changed outside its division");
  chk_high_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st.fsm != mcp_pkg::ST_DIV_HIGH) |=> (st.high == $past(st.high)))
    else $error("high time changed outside its division");

  // divider handshake and results
  chk_period_min: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st.fsm == mcp_pkg::ST_DIV_PER && div_bus.done)
    |=> (st.period[$past(st.tgt)] != 32'h00000000))
    else $error("configured period of zero clocks");
  chk_high_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st.fsm == mcp_pkg::ST_DIV_HIGH && div_bus.done)
    |=> (st.high[$past(st.tgt)] <= st.period[$past(st.tgt)]))
    else $error("high time longer than the period");
  chk_div_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st.div_start |=> !st.div_start)
    else $error("divider start longer than one cycle");
  chk_div_finish: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st.div_start |-> ##[1:40] div_bus.done)
    else $error("division did not finish");
  chk_tgt_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!idle) |-> (st.tgt < 4'(mcp_pkg::NUM_CH)))
    else $error("division aimed at a missing channel");
endmodule
`default_nettype wire

// [bench/mcp_pwm_top_test.sv]
// self-checking bench for the nine-channel pwm bank
`timescale 1ns/10ps
`default_nettype none
module mcp_pwm_top_test;
  logic clk_sys;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [mcp_pkg::NUM_PIN-1:0] pin_out;
  int miscompares;
  int cmp_count;
  int cycles;
  logic [31:0] rd_val;

  mcp_pwm_top i_mcp_pwm_top (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .pin_out(pin_out)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // whole run needs a few hundred cycles; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the read edge
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    int n;
    n = 0;
    s = 32'h00000001;
    while (s[mcp_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 200) begin
      reg_read(mcp_pkg::OFS_STATUS, s);
      n = n + 1;
    end
    chk({31'h00000000, s[mcp_pkg::STAT_BUSY_BIT]}, 32'h00000000, "busy stuck");
  endtask

  task automatic count_high(input int p, input int n, output int cnt);
    cnt = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      #1;
      if (pin_out[p] === 1'b1) begin
        cnt = cnt + 1;
      end
    end
  endtask

  task automatic set_duty_run(input logic [31:0] pct, input int exp_hi);
    int cnt;
    reg_write(mcp_pkg::OFS_DUTY, pct);
    reg_write(mcp_pkg::OFS_CMD, 32'h00000012);
    wait_idle();
    // let the running period finish so the new value is in force
    repeat (12) @(posedge clk_sys);
    count_high(3, 20, cnt);
    chk(cnt, exp_hi, "high cycles in two periods");
  endtask

  task automatic test_reset_values();
    reg_read(mcp_pkg::OFS_STATUS, rd_val);
    chk(rd_val, 32'h00000000, "status after reset");
    reg_read(mcp_pkg::OFS_FREQ, rd_val);
    chk(rd_val, mcp_pkg::FREQ_RST, "freq after reset");
    reg_read(8'h20, rd_val);
    chk(rd_val, 32'h00000000, "unmapped read");
    chk({16'h0000, pin_out}, 32'h00000000, "pins after reset");
  endtask

  task automatic test_square_wave();
    int cnt;
    // 2.5 MHz at a 25 MHz clock gives a ten-clock period
    reg_write(mcp_pkg::OFS_FREQ, 32'h002625A0);
    reg_write(mcp_pkg::OFS_DUTY, 32'h00000032);
    reg_write(mcp_pkg::OFS_CMD, 32'h00000010);
    wait_idle();
    reg_read(mcp_pkg::OFS_PERIOD_BASE, rd_val);
    chk(rd_val, 32'h0000000A, "period of channel 1");
    reg_write(mcp_pkg::OFS_CMD, 32'h00000311);
    reg_read(mcp_pkg::OFS_STATUS, rd_val);
    chk({31'h00000000, rd_val[16]}, 32'h00000001, "run bit of channel 1");
    repeat (10) @(posedge clk_sys);
    count_high(3, 20, cnt);
    chk(cnt, 10, "high cycles at half duty");
    count_high(2, 20, cnt);
    chk(cnt, 0, "unmapped pin stays low");
  endtask

  task automatic test_duty_ends_and_stop();
    int cnt;
    set_duty_run(32'h00000000, 0);
    set_duty_run(32'h00000064, 20);
    reg_write(mcp_pkg::OFS_CMD, 32'h00000013);
    repeat (4) @(posedge clk_sys);
    count_high(3, 30, cnt);
    chk(cnt, 0, "pin after stop");
    reg_read(mcp_pkg::OFS_STATUS, rd_val);
    chk({31'h00000000, rd_val[16]}, 32'h00000000, "run bit after stop");
  endtask

  task automatic test_channel_range();
    reg_write(mcp_pkg::OFS_CMD, 32'h00000000);
    reg_read(mcp_pkg::OFS_STATUS, rd_val);
    chk({31'h00000000, rd_val[1]}, 32'h00000001, "channel 0 refused");
    reg_write(mcp_pkg::OFS_CMD, 32'h000000A0);
    reg_read(mcp_pkg::OFS_STATUS, rd_val);
    chk({31'h00000000, rd_val[1]}, 32'h00000001, "channel 10 refused");
    // 1 MHz gives a 25-clock period on the last channel
    reg_write(mcp_pkg::OFS_FREQ, 32'h000F4240);
    reg_write(mcp_pkg::OFS_CMD, 32'h00000090);
    wait_idle();
    reg_read(mcp_pkg::OFS_STATUS, rd_val);
    chk({31'h00000000, rd_val[1]}, 32'h00000000, "channel 9 accepted");
    reg_read(8'h60, rd_val);
    chk(rd_val, 32'h00000019, "period of channel 9");
  endtask

  task automatic test_duty_clamp();
    reg_write(mcp_pkg::OFS_DUTY, 32'h000000C8);
    reg_read(mcp_pkg::OFS_DUTY, rd_val);
    chk(rd_val, 32'h00000064, "duty above hundred");
  endtask

  task automatic test_refusals();
    // zero hertz has no period; commands are refused while a division runs
    reg_write(mcp_pkg::OFS_FREQ, 32'h00000000);
    reg_write(mcp_pkg::OFS_CMD, 32'h00000020);
    reg_read(mcp_pkg::OFS_STATUS, rd_val);
    chk({31'h00000000, rd_val[1]}, 32'h00000001, "zero frequency refused");
    reg_write(mcp_pkg::OFS_FREQ, 32'h002625A0);
    reg_write(mcp_pkg::OFS_CMD, 32'h00000020);
    reg_write(mcp_pkg::OFS_CMD, 32'h00000521);
    wait_idle();
    reg_read(mcp_pkg::OFS_STATUS, rd_val);
    chk({30'h0, rd_val[17], rd_val[1]}, 32'h00000001, "activate while busy");
    reg_read(8'h44, rd_val);
    chk(rd_val, 32'h0000000A, "period of channel 2");
  endtask

  initial begin
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    test_reset_values();
    test_square_wave();
    test_duty_ends_and_stop();
    test_channel_range();
    test_duty_clamp();
    test_refusals();
    test_done();
  end
endmodule
`default_nettype wire
